//--- hdl/tgst_gate.sv
// timer gate conditioning: source select, polarity, toggle, gated 16-bit count, apb registers
//
// Operation
// - select 00 pin, 01 overflow pulse
// - select 10 comparator one, 11 comparator two
// - polarity bit inverts or passes every source
// - overflow wrap ff to 00 gives rising pulse
// - comparator source synchronised or asynchronous, selectable
// - toggle flip-flop flips on each rising edge
// - toggle disabled clears and holds flip-flop
// - external pin reaches the gate through polarity and toggle
// - status shows gate level, gating enabled or not
`timescale 1ns/10ps
module tgst_gate
	import tgst_pkg::*;
#(
	parameter int COUNT_W = 16,
	parameter int DIV     = TGST_TICK_DIV
)
(
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// gate sources
	input  wire logic               gate_input_pin,
	input  wire logic [7:0]         overflow_timer_count,
	input  wire logic               cmp1_output,
	input  wire logic               cmp2_output,
	// timer results
	output logic      [COUNT_W-1:0] timer_count,
	output logic                    gate_level_status
);

	// refuse widths the data bus cannot carry
	generate
		if (COUNT_W < 1 || COUNT_W > 32)
		begin : g_chk
			$error("count width must be 1 to 32");
		end
	endgenerate

	// whole module state
	typedef struct packed {
		logic               on;          // timer running
		logic               gate_enable; // gating active
		logic [1:0]         gate_source_select;
		logic               gate_polarity;
		logic               gate_toggle_enable;
		logic               cmp1_sync_en; // resync comparator one
		logic               cmp2_sync_en; // resync comparator two
		logic [COUNT_W-1:0] count;
		logic [7:0]         ovf_prev;    // last overflow timer value
		logic               ovf_pulse;   // stretched wrap pulse
		logic               cmp1_sync_output;
		logic               cmp2_sync_output;
		logic               src_prev;    // polarised source, last cycle
		logic               tog;         // toggle flip-flop
		logic               gate_val;    // conditioned gate
		logic [31:0]        prdata;
		logic               pready;
		logic               pslverr;
	} tgst_state_t;

	tgst_state_t s_q;   // registered state
	tgst_state_t s_d;   // next state
	logic        tick;  // timer incrementing edge

	// read mux, shared by read data and decode
	function automatic logic [32:0] tgst_read(input logic [7:0] a, input tgst_state_t s);
		logic [32:0] r;
		r = '0;
		unique case (a)
			TGST_OFS_CTRL:
			begin
				r[TGST_CTRL_ON_BIT]                  = s.on;
				r[TGST_CTRL_GE_BIT]                  = s.gate_enable;
				r[TGST_CTRL_SS_LSB +: 2]             = s.gate_source_select;
				r[TGST_CTRL_POL_BIT]                 = s.gate_polarity;
				r[TGST_CTRL_TM_BIT]                  = s.gate_toggle_enable;
				r[TGST_CTRL_C1S_BIT]                 = s.cmp1_sync_en;
				r[TGST_CTRL_C2S_BIT]                 = s.cmp2_sync_en;
			end
			TGST_OFS_STATUS: r[TGST_STAT_GVAL_BIT] = s.gate_val;
			TGST_OFS_COUNT:  r[COUNT_W-1:0]        = s.count;
			default:         r[32]                 = 1'b1; // unmapped: error flag
		endcase
		return r;
	endfunction

	// timer clock enable
	tgst_tick_div #(
		.DIV (DIV)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick)
	);

	// next-state logic
	always_comb
	begin
		logic        src;      // selected raw source
		logic        psrc;     // after polarity
		logic        c1;       // comparator one as used
		logic        c2;       // comparator two as used
		logic        access;   // apb access phase, first cycle
		logic        commit;   // apb transfer completes this edge
		logic [32:0] rd;       // read data and error
		src    = 1'b0;
		psrc   = 1'b0;
		c1     = 1'b0;
		c2     = 1'b0;
		access = 1'b0;
		commit = 1'b0;
		rd     = '0;
		s_d    = s_q;

		// wrap ff to 00 raises a pulse held until the next timer edge
		s_d.ovf_prev = overflow_timer_count;
		if (tick)
		begin
			s_d.ovf_pulse = 1'b0;
		end
		if (s_q.ovf_prev == TGST_OVF_MAX && overflow_timer_count == TGST_OVF_ZERO)
		begin
			s_d.ovf_pulse = 1'b1;
		end

		// comparator resync samples on the timer clock only
		if (tick)
		begin
			s_d.cmp1_sync_output = cmp1_output;
			s_d.cmp2_sync_output = cmp2_output;
		end
		c1 = s_q.cmp1_sync_en ? s_q.cmp1_sync_output : cmp1_output;
		c2 = s_q.cmp2_sync_en ? s_q.cmp2_sync_output : cmp2_output;

		// source select
		unique case (s_q.gate_source_select)
			TGST_SRC_PIN:  src = gate_input_pin;
			TGST_SRC_OVF:  src = s_q.ovf_pulse;
			TGST_SRC_CMP1: src = c1;
			TGST_SRC_CMP2: src = c2;
		endcase

		// polarity set means active high, clear inverts
		psrc = s_q.gate_polarity ? src : ~src;

		// toggle flop flips on rising edges, cleared while disabled;
		// enabling it together with a polarity change gives an arbitrary start
		s_d.src_prev = psrc;
		if (!s_q.gate_toggle_enable)
		begin
			s_d.tog = 1'b0;
		end
		else if (psrc && !s_q.src_prev)
		begin
			s_d.tog = ~s_q.tog;
		end

		// conditioned gate, also the status bit
		s_d.gate_val = s_q.gate_toggle_enable ? s_q.tog : psrc;

		// gated count advances on timer edges
		if (tick && s_q.on && (!s_q.gate_enable || s_q.gate_val))
		begin
			s_d.count = s_q.count + 1'b1;
		end

		// apb: one wait state, answer registered
		access = psel && penable && !s_q.pready;
		commit = psel && penable && s_q.pready;
		rd     = tgst_read(paddr, s_q);
		s_d.pready  = access;
		s_d.pslverr = access && rd[32];
		if (access)
		begin
			s_d.prdata = pwrite ? 32'h0000_0000 : rd[31:0];
		end

		// writes land on the completing edge; a timer write beats the increment
		if (commit && pwrite && !s_q.pslverr)
		begin
			if (paddr == TGST_OFS_CTRL)
			begin
				s_d.on                 = pwdata[TGST_CTRL_ON_BIT];
				s_d.gate_enable        = pwdata[TGST_CTRL_GE_BIT];
				s_d.gate_source_select = pwdata[TGST_CTRL_SS_LSB +: 2];
				s_d.gate_polarity      = pwdata[TGST_CTRL_POL_BIT];
				s_d.gate_toggle_enable = pwdata[TGST_CTRL_TM_BIT];
				s_d.cmp1_sync_en       = pwdata[TGST_CTRL_C1S_BIT];
				s_d.cmp2_sync_en       = pwdata[TGST_CTRL_C2S_BIT];
			end
			else if (paddr == TGST_OFS_COUNT)
			begin
				s_d.count = pwdata[COUNT_W-1:0];
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q                    <= '0;
			s_q.on                 <= TGST_CTRL_RST[TGST_CTRL_ON_BIT];
			s_q.gate_enable        <= TGST_CTRL_RST[TGST_CTRL_GE_BIT];
			s_q.gate_source_select <= TGST_CTRL_RST[TGST_CTRL_SS_LSB +: 2];
			s_q.gate_polarity      <= TGST_CTRL_RST[TGST_CTRL_POL_BIT];
			s_q.gate_toggle_enable <= TGST_CTRL_RST[TGST_CTRL_TM_BIT];
			s_q.count              <= TGST_COUNT_RST[COUNT_W-1:0];
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state flops
	assign prdata            = s_q.prdata;
	assign pready            = s_q.pready;
	assign pslverr           = s_q.pslverr;
	assign timer_count       = s_q.count;
	assign gate_level_status = s_q.gate_val;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wrap;
		overflow_timer_count == TGST_OVF_MAX ##1 overflow_timer_count == TGST_OVF_ZERO;
	endsequence

	sequence s_stat_req;
		psel && penable && !pready && !pwrite && paddr == TGST_OFS_STATUS;
	endsequence

	pin_source_a: assert property (
		s_q.gate_source_select == TGST_SRC_PIN && !s_q.gate_toggle_enable
		|=> gate_level_status == ($past(gate_input_pin) ~^ $past(s_q.gate_polarity)))
		else $error("pin source not reflected in gate level");

	wrap_pulse_a: assert property (
		s_wrap |=> s_q.ovf_pulse)
		else $error("overflow wrap gave no gate pulse");

	cmp_async_a: assert property (
		s_q.gate_source_select == TGST_SRC_CMP1 && !s_q.cmp1_sync_en && !s_q.gate_toggle_enable
		|=> gate_level_status == ($past(s_q.gate_polarity) ? $past(cmp1_output) : !$past(cmp1_output)))
		else $error("asynchronous comparator one not on gate");

	cmp_sync_a: assert property (
		!tick && s_q.cmp2_sync_en |=> $stable(s_q.cmp2_sync_output))
		else $error("synchronised comparator changed off the timer edge");

	// reachable even with a tick on every pclk: each timer edge takes a fresh sample
	cmp_resync_a: assert property (
		tick |=> s_q.cmp2_sync_output == $past(cmp2_output))
		else $error("comparator two not resampled on the timer edge");

	toggle_hold_a: assert property (
		!s_q.gate_toggle_enable [*2] |-> !s_q.tog)
		else $error("toggle flop not held clear");

	toggle_flip_a: assert property (
		s_q.gate_toggle_enable && s_d.src_prev && !s_q.src_prev
		|=> s_q.tog != $past(s_q.tog))
		else $error("toggle flop missed a rising edge");

	gate_stop_a: assert property (
		tick && s_q.on && s_q.gate_enable && !s_q.gate_val && !(psel && penable && pwrite)
		|=> timer_count == $past(timer_count))
		else $error("timer counted with gate inactive");

	status_read_a: assert property (
		s_stat_req |=> pready && prdata[TGST_STAT_GVAL_BIT] == $past(gate_level_status))
		else $error("status read does not show gate level");

	bus_answer_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle after access");

endmodule

//--- hdl/tgst_pkg.sv
// constants for the timer gate conditioning block: register map, fields, reset values
package tgst_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] TGST_OFS_CTRL   = 8'h00;
	localparam logic [7:0] TGST_OFS_STATUS = 8'h04;
	localparam logic [7:0] TGST_OFS_COUNT  = 8'h08;

	// gate_control_reg field positions
	localparam int TGST_CTRL_ON_BIT   = 0;
	localparam int TGST_CTRL_GE_BIT   = 1;
	localparam int TGST_CTRL_SS_LSB   = 2;
	localparam int TGST_CTRL_POL_BIT  = 4;
	localparam int TGST_CTRL_TM_BIT   = 5;
	localparam int TGST_CTRL_C1S_BIT  = 6;
	localparam int TGST_CTRL_C2S_BIT  = 7;

	// status field position
	localparam int TGST_STAT_GVAL_BIT = 0;

	// gate source select codes
	localparam logic [1:0] TGST_SRC_PIN  = 2'h0;
	localparam logic [1:0] TGST_SRC_OVF  = 2'h1;
	localparam logic [1:0] TGST_SRC_CMP1 = 2'h2;
	localparam logic [1:0] TGST_SRC_CMP2 = 2'h3;

	// reset values
	localparam logic [7:0]  TGST_CTRL_RST  = 8'h00;
	localparam logic [15:0] TGST_COUNT_RST = 16'h0000;

	// overflow timer wrap points
	localparam logic [7:0] TGST_OVF_MAX  = 8'hff;
	localparam logic [7:0] TGST_OVF_ZERO = 8'h00;

	// default timer clock divider: pclk cycles per incrementing edge
	localparam int TGST_TICK_DIV = 4;

endpackage

//--- hdl/tgst_tick_div.sv
// divider making the one-cycle timer clock enable from pclk
`timescale 1ns/10ps
module tgst_tick_div
	import tgst_pkg::*;
#(
	parameter int DIV = TGST_TICK_DIV
)
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// enable pulse out
	output logic      tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	// refuse a divider the counter cannot serve
	generate
		if (DIV < 1)
		begin : g_chk
			$error("tick divider must be at least 1");
		end
	endgenerate

	logic [CW-1:0] cnt_q;   // cycles since last tick
	logic          tick_q;  // registered pulse

	// count up one period, pulse at the end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (cnt_q == CW'(DIV - 1))
		begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign tick = tick_q;

endmodule

//--- test/tgst_gate_tb_top.sv
// self-checking bench for the gate conditioning block, driven over apb
`timescale 1ns/10ps
module tgst_gate_tb_top;
	import tgst_pkg::*;

	// bus, sources and results
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr, overflow_timer_count;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, gate_level_status;
	logic        gate_input_pin, cmp1_output, cmp2_output;
	logic [15:0] timer_count;
	logic        pin_lvl, c1_lvl, c2_lvl, ovf_run;
	int          mismatches, samples_checked;

	// 25 mhz clock
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// tick every pclk keeps toggle and gating walks short
	tgst_gate #(.COUNT_W(16), .DIV(1)) tgst_gate_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .gate_input_pin(gate_input_pin),
		.overflow_timer_count(overflow_timer_count), .cmp1_output(cmp1_output),
		.cmp2_output(cmp2_output), .timer_count(timer_count), .gate_level_status(gate_level_status));

	tgst_src_model tgst_src_model_i (.pclk(pclk), .presetn(presetn), .pin_lvl(pin_lvl), .c1_lvl(c1_lvl),
		.c2_lvl(c2_lvl), .ovf_run(ovf_run), .gate_input_pin(gate_input_pin), .cmp1_output(cmp1_output),
		.cmp2_output(cmp2_output), .overflow_timer_count(overflow_timer_count));

	// compare one value, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen, no bound on the wait
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic err);
		int   n;
		logic got_err;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// look between edges, where the answer is settled; only the watchdog ends a hang
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		rdat = prdata;
		got_err = pslverr;
		// the edge that completes the transfer, then release
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(n), 32'h0000_0002);
		if (!w)
			chk(rdat, exp);
		chk({31'h0, got_err}, {31'h0, err});
	endtask

	// verdict, reached from the tests and from the watchdog
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog: the whole run needs well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		finish_test();
	end

	// test sequence
	initial
	begin
		int          i, hi, ri;
		logic        e, prev;
		logic [31:0] ctl;
		{presetn, psel, penable, pwrite, pin_lvl, c1_lvl, c2_lvl, ovf_run} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		mismatches = 0;
		samples_checked = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, read-only upper count bits, unmapped place
		acc(0, TGST_OFS_CTRL, 0, {24'h0, TGST_CTRL_RST}, 0);
		acc(0, TGST_OFS_STATUS, 0, 32'h0000_0001, 0);
		acc(1, 8'h0c, 32'hffff_ffff, 0, 1);
		acc(0, 8'h0c, 0, 32'h0000_0000, 1);
		acc(1, TGST_OFS_COUNT, 32'hffff_ffff, 0, 0);
		acc(0, TGST_OFS_COUNT, 0, 32'h0000_ffff, 0);
		$display("test registers done");
		// level sources against both polarities; resync on when polarity is 1
		for (i = 0; i < 16; i++)
		begin
			if (i[3:2] == TGST_SRC_OVF)
				continue;
			ctl = {24'h0, i[1], i[1], 1'b0, i[1], i[3:2], 2'b00};
			acc(1, TGST_OFS_CTRL, ctl, 0, 0);
			pin_lvl <= (i[3:2] == TGST_SRC_PIN) ? i[0] : ~i[0];
			c1_lvl <= (i[3:2] == TGST_SRC_CMP1) ? i[0] : ~i[0];
			c2_lvl <= (i[3:2] == TGST_SRC_CMP2) ? i[0] : ~i[0];
			repeat (6) @(posedge pclk);
			chk({31'h0, gate_level_status}, {31'h0, i[0] ^ ~i[1]});
			acc(0, TGST_OFS_STATUS, 0, {31'h0, i[0] ^ ~i[1]}, 0);
			acc(0, TGST_OFS_CTRL, 0, ctl, 0);
		end
		$display("test sources done");
		// two wraps of the 8-bit timer give two pulses; gated count sees only them
		acc(1, TGST_OFS_CTRL, 32'h0000_0017, 0, 0);
		acc(1, TGST_OFS_COUNT, 32'h0000_0000, 0, 0);
		hi = 0;
		ri = 0;
		prev = 1'b0;
		ovf_run <= 1'b1;
		for (i = 0; i < 530; i++)
		begin
			@(posedge pclk);
			if (i == 520)
				ovf_run <= 1'b0;
			// sample mid-cycle, away from the edge that launches the status
			@(negedge pclk);
			hi += (gate_level_status === 1'b1);
			ri += (gate_level_status === 1'b1 && prev === 1'b0);
			prev = gate_level_status;
		end
		chk(32'(ri), 32'h0000_0002);
		chk(32'(hi), 32'h0000_0002);
		acc(0, TGST_OFS_COUNT, 0, 32'h0000_0002, 0);
		// gating on, gate held inactive: count stands still
		pin_lvl <= 1'b0;
		acc(1, TGST_OFS_CTRL, 32'h0000_0013, 0, 0);
		acc(1, TGST_OFS_COUNT, 32'h0000_0005, 0, 0);
		repeat (10) @(posedge pclk);
		acc(0, TGST_OFS_COUNT, 0, 32'h0000_0005, 0);
		chk({16'h0, timer_count}, 32'h0000_0005);
		$display("test overflow done");
		// polarity first, toggle in a later write
		acc(1, TGST_OFS_CTRL, 32'h0000_0010, 0, 0);
		acc(1, TGST_OFS_CTRL, 32'h0000_0030, 0, 0);
		e = 1'b0;
		for (i = 0; i < 6; i++)
		begin
			pin_lvl <= ~i[0];
			if (!i[0])
				e = ~e;
			repeat (6) @(posedge pclk);
			chk({31'h0, gate_level_status}, {31'h0, e});
		end
		// toggle off clears the flip-flop; back on it starts from zero
		acc(1, TGST_OFS_CTRL, 32'h0000_0010, 0, 0);
		repeat (4) @(posedge pclk);
		chk({31'h0, gate_level_status}, 32'h0);
		acc(1, TGST_OFS_CTRL, 32'h0000_0030, 0, 0);
		repeat (4) @(posedge pclk);
		chk({31'h0, gate_level_status}, 32'h0);
		$display("test toggle done");
		finish_test();
	end
endmodule

//--- test/tgst_src_model.sv
// far-side model: gate pin, two comparators and the 8-bit timer that counts while ovf_run is set
`timescale 1ns/10ps
module tgst_src_model
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// levels and run request set by the bench
	input  wire logic       pin_lvl,
	input  wire logic       c1_lvl,
	input  wire logic       c2_lvl,
	input  wire logic       ovf_run,
	// outputs towards the block
	output logic            gate_input_pin,
	output logic            cmp1_output,
	output logic            cmp2_output,
	output logic      [7:0] overflow_timer_count
);
	// outside levels reach the gate logic unchanged
	assign gate_input_pin = pin_lvl;
	assign cmp1_output    = c1_lvl;
	assign cmp2_output    = c2_lvl;

	// 8-bit timer; its ff to 00 wrap is what the block turns into a pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			overflow_timer_count <= 8'h00;
		else if (ovf_run)
			overflow_timer_count <= overflow_timer_count + 8'h01;
	end
endmodule
